// ### hw/hsi_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and an active-low reset already synchronised.
`timescale 1ns/10ps
module hsi_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic [WIDTH-1:0] in_data_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  output logic [WIDTH-1:0] out_data_out,
  output logic out_valid_out,
  input wire logic out_ready_in
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] rd_q;
  logic full;
  logic empty;

  assign full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign empty = wr_q == rd_q;
  assign in_ready_out = !full;
  assign out_valid_out = !empty;
  assign out_data_out = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      wr_q <= '0;
    else if (in_valid_in && !full)
      wr_q <= wr_q + 1'b1;
  end

  always_ff @(posedge clock_in)
  begin
    if (in_valid_in && !full)
      mem_q[wr_q[AW-1:0]] <= in_data_in;
  end

  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      rd_q <= '0;
    else if (out_ready_in && !empty)
      rd_q <= rd_q + 1'b1;
  end
endmodule

// ### hw/hsi_pkg.sv
// Package for the hall sensor I2C register slave.
// Assumes a 40 MHz system clock; all bus pins arrive asynchronously.
package hsi_pkg;

  localparam int unsigned CLK_PERIOD_NS = 25;
  // Spike rejection time and SDA hold delay, in ns.
  localparam int unsigned SPIKE_NS = 50;
  localparam int unsigned SDA_HOLD_NS = 120;
  localparam int unsigned SDA_HOLD_MAX_NS = 260;
  // Least time rounds up for the spike filter; hold delay rounds down.
  localparam int unsigned SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SDA_HOLD_CYC = (SDA_HOLD_NS / CLK_PERIOD_NS) < 1 ? 1 : (SDA_HOLD_NS / CLK_PERIOD_NS);

  // Upper six address bits are fixed; the lowest follows the select pin.
  localparam logic [5:0] DEV_ADDR_HI = 6'h2b;

  localparam logic [7:0] IDX_RESULT_LO = 8'h00;
  localparam logic [7:0] IDX_RESULT_HI = 8'h01;
  localparam logic [7:0] IDX_OP_CFG = 8'h02;
  localparam logic [7:0] IDX_TRIM_LO = 8'h03;
  localparam logic [7:0] IDX_TRIM_HI = 8'h04;
  localparam logic [7:0] IDX_GAIN = 8'h0b;

  localparam int unsigned CFG_PD_BIT = 0;
  localparam int unsigned CFG_POL_BIT = 1;
  localparam int unsigned CFG_SLOW_BIT = 2;
  localparam int unsigned HI_PARITY_BIT = 2;
  localparam int unsigned HI_OCF_BIT = 3;

  localparam logic [7:0] OP_CFG_RST = 8'h00;
  localparam logic [7:0] GAIN_RST = 8'h00;
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam int unsigned FIFO_DEPTH = 16;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR_BYTE = 3'b011,
    ST_WR_ACK = 3'b100,
    ST_RD_BYTE = 3'b101,
    ST_RD_ACK = 3'b110
  } hsi_state_e;

  // One received register write, queued toward the register file.
  typedef struct packed {
    logic [7:0] idx;
    logic [7:0] data;
  } hsi_wr_s;

  // Settings handed to the sensor core.
  typedef struct packed {
    logic power_down;
    logic pol_reversed;
    logic slow_mode;
    logic [1:0] gain_range;
  } hsi_cfg_s;

endpackage

// ### hw/hsi_slave.sv
// I2C register slave of the linear hall sensor: filters, protocol engine, registers.
// Assumes SCL and SDA are sampled asynchronous pins and the sensor core drives result inputs.
// Functional notes
// - STOP or repeated START ends a transfer; repeated START restarts address phase.
// - Every byte travels most significant bit first.
// - First byte holds 7-bit address plus direction; acknowledged on match.
// - Byte after write address loads pointer; acknowledged only if index valid.
// - Writes to invalid or read-only index are dropped with NACK; writable ones stored and acknowledged.
// - Pointer advances after every data byte, read or write, valid or not.
// - Reads start at current pointer, kept from the previous access.
// - Reading an invalid index returns zero and still advances the pointer.
// - Sequential access runs across all indices, wrapping around.
// - SDA and SCL filters reject pulses shorter than 50 ns.
// - SDA is delayed 100 ns (four clocks), under 260 ns, before start/stop detection.
// - Result low byte at 00h, upper two bits at 01h bits 1:0.
// - Index 01h bit 2 is even parity over the ten result bits.
// - Index 01h bit 3 shows offset loop done.
// - Index 02h bit 0 selects power down; default normal.
// - Index 02h bit 1 selects reversed polarity; default normal.
// - Index 02h bit 2 selects slow averaging mode; default fast.
// - Indices 03h/04h show the 10-bit compensation value kept by device.
// - Index 0Bh bits 1:0 select input range; default code 0.
// - Address is fixed upper six bits, lowest bit from select pin.
// - The slave never stretches SCL.
`timescale 1ns/10ps
module hsi_slave (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n_out,
  input wire logic addr_sel_in,
  input wire logic [9:0] field_result_bits_in,
  input wire logic offset_loop_done_in,
  input wire logic [9:0] comp_trim_value_in,
  input wire logic comp_trim_load_in,
  output hsi_pkg::hsi_cfg_s cfg_out,
  output logic [9:0] comp_trim_value_out
);

  ////////////////////////////////////////////////////////////////////////////
  logic rst_m_q;
  logic rstn_q;
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      rst_m_q <= 1'b0;
      rstn_q <= 1'b0;
    end
    else
    begin
      rst_m_q <= 1'b1;
      rstn_q <= rst_m_q;
    end
  end

  function automatic logic valid_idx(input logic [7:0] idx);
    valid_idx = (idx <= hsi_pkg::IDX_TRIM_HI) || (idx == hsi_pkg::IDX_GAIN);
  endfunction
  function automatic logic writable_idx(input logic [7:0] idx);
    writable_idx = valid_idx(idx) && (idx >= hsi_pkg::IDX_OP_CFG);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, then spike filters that accept a level only after it held.
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [1:0] sel_sync_q;
  logic [2:0] scl_cnt_q;
  logic [2:0] sda_cnt_q;
  logic scl_f_q;
  logic sda_f_q;
  logic [hsi_pkg::SDA_HOLD_CYC-1:0] sda_dly_q;
  logic scl_prev_q;
  logic sda_dly_prev_q;

  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      sel_sync_q <= 2'b00;
    end
    else
    begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      sel_sync_q <= {sel_sync_q[0], addr_sel_in};
    end
  end

  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      scl_cnt_q <= '0;
      scl_f_q <= 1'b1;
    end
    else if (scl_sync_q[1] == scl_f_q)
      scl_cnt_q <= '0;
    else if (scl_cnt_q >= 3'(hsi_pkg::SPIKE_CYC))
    begin
      scl_f_q <= scl_sync_q[1];
      scl_cnt_q <= '0;
    end
    else
      scl_cnt_q <= scl_cnt_q + 3'h1;
  end

  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      sda_cnt_q <= '0;
      sda_f_q <= 1'b1;
    end
    else if (sda_sync_q[1] == sda_f_q)
      sda_cnt_q <= '0;
    else if (sda_cnt_q >= 3'(hsi_pkg::SPIKE_CYC))
    begin
      sda_f_q <= sda_sync_q[1];
      sda_cnt_q <= '0;
    end
    else
      sda_cnt_q <= sda_cnt_q + 3'h1;
  end

  // The delayed SDA copy bridges the slow SCL fall so data changes are not seen as start/stop.
  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      sda_dly_q <= '1;
      scl_prev_q <= 1'b1;
      sda_dly_prev_q <= 1'b1;
    end
    else
    begin
      sda_dly_q <= {sda_dly_q[hsi_pkg::SDA_HOLD_CYC-2:0], sda_f_q};
      scl_prev_q <= scl_f_q;
      sda_dly_prev_q <= sda_dly_q[hsi_pkg::SDA_HOLD_CYC-1];
    end
  end

  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  assign sda_d = sda_dly_q[hsi_pkg::SDA_HOLD_CYC-1];
  assign scl_rise = scl_f_q && !scl_prev_q;
  assign scl_fall = !scl_f_q && scl_prev_q;
  assign start_ev = scl_f_q && scl_prev_q && sda_dly_prev_q && !sda_d;
  assign stop_ev = scl_f_q && scl_prev_q && !sda_dly_prev_q && sda_d;

  ////////////////////////////////////////////////////////////////////////////
  // Protocol engine. Bits are sampled at SCL rise; SDA changes only after SCL fall.
  hsi_pkg::hsi_state_e state_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] ptr_q;
  logic ptr_seen_q;
  logic ack_q;
  logic master_nack_q;
  logic [7:0] tx_q;
  logic [7:0] rd_data;
  logic wr_valid;
  logic wr_ready;
  hsi_pkg::hsi_wr_s wr_item;
  logic byte_done;

  assign byte_done = scl_fall && (bit_q == 4'h8);
  assign wr_item.idx = ptr_q;
  assign wr_item.data = shift_q;
  // A data byte goes to the queue at the end of its ACK slot, only for writable indices.
  assign wr_valid = (state_q == hsi_pkg::ST_WR_ACK) && scl_fall && ack_q && ptr_seen_q;

  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
      bit_q <= '0;
    else if (start_ev || scl_fall && (state_q == hsi_pkg::ST_ADDR_ACK || state_q == hsi_pkg::ST_WR_ACK
             || state_q == hsi_pkg::ST_RD_ACK))
      bit_q <= '0;
    else if (scl_rise && bit_q < 4'h8)
      bit_q <= bit_q + 4'h1;
  end

  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
      shift_q <= '0;
    else if (scl_rise && bit_q < 4'h8)
      shift_q <= {shift_q[6:0], sda_f_q};
  end

  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
      state_q <= hsi_pkg::ST_IDLE;
    else if (start_ev)
      state_q <= hsi_pkg::ST_ADDR;
    else if (stop_ev)
      state_q <= hsi_pkg::ST_IDLE;
    else
    begin
      case (state_q)
        hsi_pkg::ST_IDLE: state_q <= hsi_pkg::ST_IDLE;
        hsi_pkg::ST_ADDR:
          if (byte_done)
            state_q <= (shift_q[7:1] == {hsi_pkg::DEV_ADDR_HI, sel_sync_q[1]}) ? hsi_pkg::ST_ADDR_ACK
                       : hsi_pkg::ST_IDLE;
        hsi_pkg::ST_ADDR_ACK:
          if (scl_fall)
            state_q <= shift_q[0] ? hsi_pkg::ST_RD_BYTE : hsi_pkg::ST_WR_BYTE;
        hsi_pkg::ST_WR_BYTE:
          if (byte_done)
            state_q <= hsi_pkg::ST_WR_ACK;
        hsi_pkg::ST_WR_ACK:
          if (scl_fall)
            state_q <= hsi_pkg::ST_WR_BYTE;
        hsi_pkg::ST_RD_BYTE:
          if (byte_done)
            state_q <= hsi_pkg::ST_RD_ACK;
        hsi_pkg::ST_RD_ACK:
          if (scl_fall)
            state_q <= master_nack_q ? hsi_pkg::ST_IDLE : hsi_pkg::ST_RD_BYTE;
        default: state_q <= hsi_pkg::ST_IDLE;
      endcase
    end
  end

  // Master acknowledge is sampled at SCL rise of the ninth read clock.
  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
      master_nack_q <= 1'b0;
    else if (state_q == hsi_pkg::ST_RD_ACK && scl_rise)
      master_nack_q <= sda_f_q;
  end

  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      ptr_q <= hsi_pkg::PTR_RST;
      ptr_seen_q <= 1'b0;
      ack_q <= 1'b0;
    end
    else if (start_ev)
      ptr_seen_q <= 1'b0;
    else if (state_q == hsi_pkg::ST_ADDR && byte_done)
      ack_q <= 1'b1;
    else if (state_q == hsi_pkg::ST_WR_BYTE && byte_done)
    begin
      if (!ptr_seen_q)
      begin
        ptr_q <= shift_q;
        ack_q <= valid_idx(shift_q);
      end
      else
        ack_q <= writable_idx(ptr_q) && wr_ready;
    end
    else if (state_q == hsi_pkg::ST_WR_ACK && scl_fall)
    begin
      if (ptr_seen_q)
        ptr_q <= ptr_q + 8'h01;
      ptr_seen_q <= 1'b1;
    end
    else if (state_q == hsi_pkg::ST_RD_BYTE && byte_done)
      ptr_q <= ptr_q + 8'h01;
  end

  // Transmit byte is loaded from the pointer at each read byte start.
  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
      tx_q <= '0;
    else if (scl_fall && (state_q == hsi_pkg::ST_ADDR_ACK || state_q == hsi_pkg::ST_RD_ACK))
      tx_q <= rd_data;
    else if (state_q == hsi_pkg::ST_RD_BYTE && scl_fall)
      tx_q <= {tx_q[6:0], 1'b0};
  end

  // Open-drain drive; SDA changes only on SCL fall so no stretching is ever needed.
  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
      sda_oe_n_out <= 1'b1;
    else if (start_ev || stop_ev)
      sda_oe_n_out <= 1'b1;
    else if (scl_fall)
    begin
      if ((state_q == hsi_pkg::ST_ADDR || state_q == hsi_pkg::ST_WR_BYTE) && bit_q == 4'h8)
        sda_oe_n_out <= !(state_q == hsi_pkg::ST_ADDR ?
          (shift_q[7:1] == {hsi_pkg::DEV_ADDR_HI, sel_sync_q[1]}) : (ptr_seen_q ? (writable_idx(ptr_q) && wr_ready)
          : valid_idx(shift_q)));
      else if (state_q == hsi_pkg::ST_ADDR_ACK && shift_q[0])
        sda_oe_n_out <= rd_data[7];
      else if (state_q == hsi_pkg::ST_RD_ACK && !master_nack_q)
        sda_oe_n_out <= rd_data[7];
      else if (state_q == hsi_pkg::ST_RD_BYTE && bit_q < 4'h8)
        sda_oe_n_out <= tx_q[6];
      else
        sda_oe_n_out <= 1'b1;
    end
  end

  assign sda_out = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Register file. Writes pass through a queue so the bit engine never waits on it.
  logic [7:0] op_cfg_q;
  logic [7:0] trim_lo_q;
  logic [7:0] trim_hi_q;
  logic [7:0] gain_q;
  hsi_pkg::hsi_wr_s q_item;
  logic q_valid;

  hsi_fifo #(.WIDTH(16), .DEPTH(hsi_pkg::FIFO_DEPTH)) u_wr_fifo (
    .clock_in(clock_in),
    .rstn_in(rstn_q),
    .in_data_in(wr_item),
    .in_valid_in(wr_valid),
    .in_ready_out(wr_ready),
    .out_data_out(q_item),
    .out_valid_out(q_valid),
    .out_ready_in(1'b1)
  );

  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      op_cfg_q <= hsi_pkg::OP_CFG_RST;
      gain_q <= hsi_pkg::GAIN_RST;
    end
    else if (q_valid)
    begin
      if (q_item.idx == hsi_pkg::IDX_OP_CFG)
        op_cfg_q <= q_item.data;
      if (q_item.idx == hsi_pkg::IDX_GAIN)
        gain_q <= q_item.data;
    end
  end

  // The trim value belongs to the device; a load from the core wins over a bus write.
  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      trim_lo_q <= '0;
      trim_hi_q <= '0;
    end
    else if (comp_trim_load_in)
    begin
      trim_lo_q <= comp_trim_value_in[7:0];
      trim_hi_q <= {trim_hi_q[7:2], comp_trim_value_in[9:8]};
    end
    else if (q_valid)
    begin
      if (q_item.idx == hsi_pkg::IDX_TRIM_LO)
        trim_lo_q <= q_item.data;
      if (q_item.idx == hsi_pkg::IDX_TRIM_HI)
        trim_hi_q <= q_item.data;
    end
  end

  always_comb
  begin
    case (ptr_q)
      hsi_pkg::IDX_RESULT_LO: rd_data = field_result_bits_in[7:0];
      hsi_pkg::IDX_RESULT_HI: rd_data = {4'h0, offset_loop_done_in, ^field_result_bits_in,
                                         field_result_bits_in[9:8]};
      hsi_pkg::IDX_OP_CFG: rd_data = op_cfg_q;
      hsi_pkg::IDX_TRIM_LO: rd_data = trim_lo_q;
      hsi_pkg::IDX_TRIM_HI: rd_data = trim_hi_q;
      hsi_pkg::IDX_GAIN: rd_data = gain_q;
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clock_in or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      cfg_out <= '0;
      comp_trim_value_out <= '0;
    end
    else
    begin
      cfg_out.power_down <= op_cfg_q[hsi_pkg::CFG_PD_BIT];
      cfg_out.pol_reversed <= op_cfg_q[hsi_pkg::CFG_POL_BIT];
      cfg_out.slow_mode <= op_cfg_q[hsi_pkg::CFG_SLOW_BIT];
      cfg_out.gain_range <= gain_q[1:0];
      comp_trim_value_out <= {trim_hi_q[1:0], trim_lo_q};
    end
  end
endmodule

// ### testbench/hsi_bus_master.sv
// Behavioural I2C bus master facing the slave's pins.
// Assumes an external pull-up: a released SDA reads high on the wire.
`timescale 1ns/10ps
module hsi_bus_master (
  output logic scl_out,
  output logic sda_out,
  input wire logic sda_in
);
  localparam int unsigned STEP_NS = 200;
  logic glitch_q;
  initial
  begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    glitch_q = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Serves as a repeated start too, since SDA is released while SCL is low.
  task automatic start();
    sda_out = 1'b1;
    #(STEP_NS * 3);
    scl_out = 1'b1;
    #(STEP_NS * 2);
    sda_out = 1'b0;
    #(STEP_NS * 2);
    scl_out = 1'b0;
  endtask
  task automatic stop();
    #(STEP_NS);
    sda_out = 1'b0;
    #(STEP_NS * 2);
    scl_out = 1'b1;
    #(STEP_NS * 2);
    sda_out = 1'b1;
    #(STEP_NS * 2);
  endtask
  // The optional spike is a short SCL pulse with SDA steady, so a slave that let it through would shift an extra bit.
  task automatic bit_cycle(input logic b, output logic seen);
    #(STEP_NS);
    sda_out = b;
    #(STEP_NS);
    if (glitch_q)
    begin
      scl_out = 1'b1;
      #40;
      scl_out = 1'b0;
      glitch_q = 1'b0;
      // Pads the spike to two clock periods so later edges keep their place after the clock edge.
      #10;
    end
    #(STEP_NS);
    scl_out = 1'b1;
    #(STEP_NS);
    seen = sda_in;
    #(STEP_NS);
    scl_out = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cycle(b[i], s);
    bit_cycle(1'b1, s);
    ack = ~s;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bit_cycle(1'b1, s);
      b[i] = s;
    end
    bit_cycle(last, s);
  endtask
endmodule

// ### testbench/hsi_slave_sva.sv
// Concurrent checks on the ports of the hall sensor I2C register slave.
// Assumes the bind below and an SCL low phase much longer than the answer latency.
`timescale 1ns/10ps
module hsi_slave_chk (
  input wire logic clock_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n_out,
  input wire logic addr_sel_in,
  input wire logic [9:0] field_result_bits_in,
  input wire logic offset_loop_done_in,
  input wire logic [9:0] comp_trim_value_in,
  input wire logic comp_trim_load_in,
  input wire hsi_pkg::hsi_cfg_s cfg_out,
  input wire logic [9:0] comp_trim_value_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);
  logic [9:0] trim_cap_q;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clock_in or negedge rstn_in)
  begin
    if (!rstn_in)
      trim_cap_q <= 10'h000;
    else if (comp_trim_load_in)
      trim_cap_q <= comp_trim_value_in;
  end
  ////////////////////////////////////////////////////////////////////////////
  chk_reset_idle: assert property ($rose(rstn_in) |-> sda_oe_n_out && cfg_out == '0)
    else $error("outputs not idle after reset");
  chk_drive_late: assert property ($fell(sda_oe_n_out) |-> !scl_in && !$past(scl_in, 4))
    else $error("slave pulled SDA outside the SCL low phase");
  chk_release_low: assert property ($rose(sda_oe_n_out) |-> !scl_in && !$past(scl_in, 4))
    else $error("slave released SDA while SCL high");
  chk_drive_holds: assert property (!sda_oe_n_out && $rose(scl_in) |-> !sda_oe_n_out [*8])
    else $error("SDA drive changed during SCL high");
  chk_answer_lat: assert property ($fell(scl_in) |-> $stable(sda_oe_n_out) [*4])
    else $error("SDA changed too soon after SCL fall");
  chk_cfg_quiet: assert property ($changed(cfg_out) |-> !scl_in && !$past(scl_in, 4))
    else $error("settings changed outside an acknowledge");
  chk_trim_load: assert property (comp_trim_load_in |=> ##[0:1] comp_trim_value_out == trim_cap_q)
    else $error("core trim value not taken");
  chk_trim_quiet: assert property ($changed(comp_trim_value_out)
    |-> $past(comp_trim_load_in) || $past(comp_trim_load_in, 2) || !scl_in)
    else $error("trim value changed without cause");
  cov_ack: cover property ($fell(sda_oe_n_out));
  cov_cfg: cover property ($changed(cfg_out));
  cov_trim: cover property (comp_trim_load_in ##2 1'b1);
endmodule
bind hsi_slave hsi_slave_chk chk (.clock_in(clock_in), .rstn_in(rstn_in), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .addr_sel_in(addr_sel_in),
  .field_result_bits_in(field_result_bits_in), .offset_loop_done_in(offset_loop_done_in),
  .comp_trim_value_in(comp_trim_value_in), .comp_trim_load_in(comp_trim_load_in), .cfg_out(cfg_out),
  .comp_trim_value_out(comp_trim_value_out));

// ### testbench/test_hall_sensor_i2c_register_slave.sv
// Self-checking bench for the hall sensor I2C register slave.
// Assumes hsi_bus_master as bus partner and a pull-up on SDA.
`timescale 1ns/10ps
module test_hall_sensor_i2c_register_slave;
  logic clock_in = 1'b0;
  logic rstn_in = 1'b0;
  logic addr_sel = 1'b1;
  logic [9:0] res_bits = 10'h000;
  logic offset_loop_done = 1'b0;
  logic [9:0] trim_in = 10'h000;
  logic trim_load = 1'b0;
  logic scl, m_sda, s_sda, s_oe_n, sda_wire;
  hsi_pkg::hsi_cfg_s cfg;
  logic [9:0] trim_out;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  int ptr = 0;
  logic [7:0] mem [256];
  logic [31:0] rnd = 32'h00001849;
  assign sda_wire = m_sda & (s_oe_n | s_sda);
  always #12.5 clock_in = ~clock_in;
  hsi_bus_master m (.scl_out(scl), .sda_out(m_sda), .sda_in(sda_wire));
  hsi_slave dut (.clock_in(clock_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(s_sda),
    .sda_oe_n_out(s_oe_n), .addr_sel_in(addr_sel), .field_result_bits_in(res_bits), .offset_loop_done_in(offset_loop_done),
    .comp_trim_value_in(trim_in), .comp_trim_load_in(trim_load), .cfg_out(cfg), .comp_trim_value_out(trim_out));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] rand8();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd[7:0];
  endfunction
  function automatic bit valid(input int i);
    return i <= 4 || i == 11;
  endfunction
  function automatic bit writable(input int i);
    return i >= 2 && valid(i);
  endfunction
  function automatic logic [7:0] exp_rd(input int i);
    case (i)
      0: return res_bits[7:0];
      1: return {4'h0, offset_loop_done, ^res_bits, res_bits[9:8]};
      2, 3, 4, 11: return mem[i];
      default: return 8'h00;
    endcase
  endfunction
  task automatic tick();
    @(posedge clock_in);
    #2;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic addr(input logic rd, input logic ok);
    logic a;
    m.start();
    m.wbyte({hsi_pkg::DEV_ADDR_HI, addr_sel ~^ ok, rd}, a);
    chk("address ack", ok, a);
  endtask
  task automatic set_ptr(input int p);
    logic a;
    addr(1'b0, 1'b1);
    m.wbyte(p[7:0], a);
    ptr = p;
    chk("pointer ack", valid(p), a);
  endtask
  task automatic wr(input logic [7:0] d);
    logic a;
    m.wbyte(d, a);
    chk("data ack", writable(ptr), a);
    if (writable(ptr))
      mem[ptr] = d;
    ptr = (ptr + 1) % 256;
  endtask
  task automatic rd_seq(input int n);
    logic [7:0] b;
    addr(1'b1, 1'b1);
    for (int k = 0; k < n; k++)
    begin
      m.rbyte(k == n - 1, b);
      chk("read data", exp_rd(ptr), b);
      ptr = (ptr + 1) % 256;
    end
    m.stop();
  endtask
  task automatic chk_out();
    chk("settings", {mem[2][0], mem[2][1], mem[2][2], mem[11][1:0]}, cfg);
    chk("trim out", {mem[4][1:0], mem[3]}, trim_out);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      err_total++;
      summarize();
    end
  end
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h00;
    repeat (3) @(posedge clock_in);
    #2;
    rstn_in = 1'b1;
    repeat (12) tick();
    res_bits = 10'({rand8(), rand8()});
    offset_loop_done = rnd[3];
    chk_out();
    // Pointer write, then repeated start into a read across invalid indices.
    set_ptr(0);
    rd_seq(13);
    set_ptr(2);
    m.glitch_q = 1'b1;
    for (int k = 0; k < 10; k++)
      wr(rand8());
    m.stop();
    chk_out();
    set_ptr(2);
    rd_seq(10);
    for (int g = 0; g < 4; g++)
    begin
      set_ptr(11);
      wr({mem[11][7:2], g[1:0]});
      m.stop();
      chk_out();
    end
    set_ptr(0);
    wr(8'h5a);
    wr(8'ha5);
    m.stop();
    set_ptr(254);
    repeat (3) wr(rand8());
    m.stop();
    rd_seq(2);
    tick();
    trim_in = 10'({rand8(), rand8()});
    trim_load = 1'b1;
    tick();
    trim_load = 1'b0;
    mem[3] = trim_in[7:0];
    mem[4][1:0] = trim_in[9:8];
    repeat (4) tick();
    chk_out();
    set_ptr(3);
    rd_seq(1);
    res_bits = 10'({rand8(), rand8()});
    offset_loop_done = ~offset_loop_done;
    set_ptr(0);
    rd_seq(2);
    addr(1'b0, 1'b0);
    m.stop();
    rd_seq(1);
    // The other address select level must move the device address with it.
    addr_sel = 1'b0;
    repeat (3) tick();
    rd_seq(1);
    summarize();
  end
endmodule
